// ===== shared/dot_pkg.sv
package dot_pkg;

    // ======================================================
    // Register map (byte addresses)
    // ======================================================
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_LAT    = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // ======================================================
    // Control register fields
    // ======================================================
    localparam int CTRL_NOM_LSB  = 0;   // Nominal termination code, 3 bits
    localparam int CTRL_NOM_W    = 3;
    localparam int CTRL_WR_LSB   = 3;   // Write termination code, 2 bits
    localparam int CTRL_WR_W     = 2;
    localparam int CTRL_KEEP_BIT = 5;   // DLL kept on in precharge PD
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // ======================================================
    // Latency register fields
    // ======================================================
    localparam int LAT_CWL_LSB = 0;
    localparam int LAT_AL_LSB  = 4;
    localparam int LAT_FLD_W   = 4;
    localparam logic [3:0] CWL_RESET = 4'h5;
    localparam logic [3:0] AL_RESET  = 4'h0;

    // ======================================================
    // Status register fields
    // ======================================================
    localparam int STAT_RTT_BIT  = 0;
    localparam int STAT_ODT_BIT  = 1;
    localparam int STAT_SYNC_BIT = 2;
    localparam int STAT_CKE_BIT  = 3;

    // ======================================================
    // Timing
    // ======================================================
    localparam logic [4:0] LAT_OFFSET = 5'h02;  // ODT latency = WL - 2
    localparam logic [4:0] LAT_MIN    = 5'h01;
    localparam int         HIST_W     = 32;

endpackage

// ===== src/dot_odt_ctrl.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - Termination switched per rank by ODT
// - Self-refresh: termination off, ODT ignored
// - ODT ignored when mode disables termination
// - Nonzero nominal or write code enables
// - ODT low off; high on unless disabled or out of synchronous mode
// - No read or write command decoding
// - Synchronous timing when DLL locked and CKE high or keep bit set
// - RTT follows ODT after fixed latency
// - Additive latency delays internal ODT
// - Latency equals CWL plus AL minus two, never below one
// - Termination returns when drivers release
module dot_odt_ctrl
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // Pins from the controller
    input  wire logic        odtPin,
    input  wire logic        ckePin,
    // Device-internal state
    input  wire logic        selfRefresh,
    input  wire logic        dllLocked,
    input  wire logic        dqDriving,
    // Termination switch
    output logic             rttOn,
    output logic      [2:0]  rttNomSel,
    output logic      [1:0]  rttWrSel
);

    // ======================================================
    // Functions
    // ======================================================
    function automatic logic [4:0] calcLat(input logic [3:0] cwl,
                                           input logic [3:0] al);
        logic [4:0] sum;
        sum = {1'b0, cwl} + {1'b0, al};
        if (sum > dot_pkg::LAT_OFFSET + dot_pkg::LAT_MIN)
            calcLat = sum - dot_pkg::LAT_OFFSET;
        else
            calcLat = dot_pkg::LAT_MIN;
    endfunction

    // ======================================================
    // Pin synchronisers
    // ======================================================
    logic odtMeta;
    logic odtS;
    logic ckeMeta;
    logic ckeS;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            odtMeta <= 1'b0;
            odtS    <= 1'b0;
            ckeMeta <= 1'b0;
            ckeS    <= 1'b0;
        end
        else
        begin
            odtMeta <= odtPin;
            odtS    <= odtMeta;
            ckeMeta <= ckePin;
            ckeS    <= ckeMeta;
        end
    end

    // ======================================================
    // Register file
    // ======================================================
    logic [5:0]  ctrl;
    logic [3:0]  cwl;
    logic [3:0]  al;
    logic [5:0]  next_ctrl;
    logic [3:0]  next_cwl;
    logic [3:0]  next_al;
    logic [31:0] next_regRdata;
    logic        syncMode;
    logic        termEnabled;

    always_comb
    begin
        next_ctrl     = ctrl;
        next_cwl      = cwl;
        next_al       = al;
        next_regRdata = 32'h0000_0000;
        if (regWr && regAddr == dot_pkg::ADDR_CTRL)
            next_ctrl = regWdata[5:0];
        if (regWr && regAddr == dot_pkg::ADDR_LAT)
        begin
            next_cwl = regWdata[dot_pkg::LAT_CWL_LSB +: dot_pkg::LAT_FLD_W];
            next_al  = regWdata[dot_pkg::LAT_AL_LSB +: dot_pkg::LAT_FLD_W];
        end
        if (regRd)
        begin
            case (regAddr)
                dot_pkg::ADDR_CTRL:
                    next_regRdata = {26'h000_0000, ctrl};
                dot_pkg::ADDR_LAT:
                    next_regRdata = {24'h00_0000, al, cwl};
                dot_pkg::ADDR_STATUS:
                begin
                    next_regRdata[dot_pkg::STAT_RTT_BIT]  = rttOn;
                    next_regRdata[dot_pkg::STAT_ODT_BIT]  = odtS;
                    next_regRdata[dot_pkg::STAT_SYNC_BIT] = syncMode;
                    next_regRdata[dot_pkg::STAT_CKE_BIT]  = ckeS;
                end
                default:
                    next_regRdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl     <= dot_pkg::CTRL_RESET;
            cwl      <= dot_pkg::CWL_RESET;
            al       <= dot_pkg::AL_RESET;
            regRdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl     <= next_ctrl;
            cwl      <= next_cwl;
            al       <= next_al;
            regRdata <= next_regRdata;
        end
    end

    // ======================================================
    // Termination control
    // ======================================================
    logic [dot_pkg::HIST_W-1:0] odtHist;
    logic [dot_pkg::HIST_W-1:0] next_odtHist;
    logic [4:0]                 odtLat;
    logic                       odtTap;
    logic                       next_rttOn;
    logic [2:0]                 nomCode;
    logic [1:0]                 wrCode;

    assign nomCode = ctrl[dot_pkg::CTRL_NOM_LSB +: dot_pkg::CTRL_NOM_W];
    assign wrCode  = ctrl[dot_pkg::CTRL_WR_LSB +: dot_pkg::CTRL_WR_W];
    // Any nonzero code enables and also selects the strength
    assign termEnabled = (nomCode != 3'h0) || (wrCode != 2'h0);
    // Slow-exit precharge PD freezes the DLL; CKE low then leaves sync
    assign syncMode = dllLocked
                   && (ckeS || ctrl[dot_pkg::CTRL_KEEP_BIT]);
    // Latency is CWL plus AL less two, never below one, AL posting the pin
    assign odtLat = calcLat(cwl, al);
    assign odtTap = odtHist[odtLat - 5'h01];

    always_comb
    begin
        // Self-refresh flushes history so ODT is ignored there
        if (selfRefresh)
            next_odtHist = '0;
        else
            next_odtHist = {odtHist[dot_pkg::HIST_W-2:0], odtS};
        // Only the pin, mode and driver state matter: no command decode
        next_rttOn = odtTap && termEnabled && syncMode
                  && !selfRefresh
                  && !dqDriving;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            odtHist   <= '0;
            rttOn     <= 1'b0;
            rttNomSel <= 3'h0;
            rttWrSel  <= 2'h0;
        end
        else
        begin
            odtHist   <= next_odtHist;
            rttOn     <= next_rttOn;
            rttNomSel <= nomCode;
            rttWrSel  <= wrCode;
        end
    end

    // ======================================================
    // Assertions
    // ======================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_self_ref_off:
        assert property (selfRefresh |=> !rttOn)
        else $error("Termination on during self-refresh");
    a_mode_disable_off:
        assert property (!termEnabled |=> !rttOn)
        else $error("Termination on while disabled by mode");
    a_code_selects:
        assert property (rttOn |-> (rttNomSel != 3'h0)
                                || (rttWrSel != 2'h0))
        else $error("Termination on with zero strength codes");
    a_odt_high_on:
        assert property (odtTap && termEnabled && syncMode
                         && !selfRefresh && !dqDriving |=> rttOn)
        else $error("Termination not on for sampled ODT high");
    a_odt_low_off:
        assert property (rttOn |-> $past(odtTap))
        else $error("Termination on without ODT high");
    a_lat_min:
        assert property (odtLat == 5'h03 && !selfRefresh
                         && $past(!selfRefresh, 3)
                         |-> odtTap == $past(odtS, 3))
        else $error("Turn latency wrong at minimum setting");
    a_lat_posted:
        assert property (odtLat == 5'h06 && !selfRefresh
                         && $past(!selfRefresh, 6)
                         |-> odtTap == $past(odtS, 6))
        else $error("Posted latency wrong");
    a_sync_only:
        assert property (!syncMode |=> !rttOn)
        else $error("Termination on outside synchronous mode");
    a_drive_release:
        assert property (dqDriving |=> !rttOn)
        else $error("Termination on while driving data");

    // ======================================================
    // Further checks on the switch and the register port
    // ======================================================
    a_off_follows:
        assert property (!odtTap |=> !rttOn)
        else $error("Termination on after delayed ODT low");

    a_nom_follow:
        assert property (rttNomSel == $past(nomCode))
        else $error("Nominal strength code not registered");

    a_wr_follow:
        assert property (rttWrSel == $past(wrCode))
        else $error("Write strength code not registered");

    a_term_enable:
        assert property (termEnabled == (ctrl[4:0] != 5'h00))
        else $error("Termination enable not from codes");

    // Clamp keeps the tap index inside the history
    a_lat_range:
        assert property (odtLat >= 5'h01 && odtLat <= 5'h1C)
        else $error("Latency outside history range");

    a_lat_formula:
        assert property (({1'b0, cwl} + {1'b0, al}) > 5'h03
                         |-> odtLat == {1'b0, cwl} + {1'b0, al}
                                       - 5'h02)
        else $error("Latency not CWL plus AL less two");

    a_hist_flush:
        assert property (selfRefresh |=> odtHist == '0)
        else $error("History kept through self-refresh");

    // Read data must not linger once the strobe has passed
    a_rdata_idle:
        assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("Read data outside its cycle");

    a_sync_keep:
        assert property (dllLocked && ckeS |-> syncMode)
        else $error("Sync mode lost with DLL locked");

    c_rtt_on:       cover property ($rose(rttOn));
    c_read_release: cover property ($fell(dqDriving) ##1 rttOn);
    c_pd_keep:      cover property (!ckeS && syncMode && rttOn);
    c_self_ref:     cover property (rttOn ##1 selfRefresh);

endmodule

// ===== test/dot_ctrl_model.sv
`timescale 1ns/10ps
// ==========================================
// Controller side of the ODT and CKE pins
module dot_ctrl_model
#(
    parameter int HOLD = 6
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Bench requests
    input  wire logic odtReq,
    input  wire logic ckeReq,
    // Pins
    output logic      odtPin,
    output logic      ckePin
);
    int odtCnt;
    int ckeCnt;

    // One hold figure serves ODTH4 and ODTH8, whichever ends later
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            odtPin <= 1'b0;
            ckePin <= 1'b1;
            odtCnt <= 0;
            ckeCnt <= 0;
        end
        else
        begin
            odtPin <= odtReq || (odtPin && odtCnt < HOLD);
            odtCnt <= odtPin ? odtCnt + 1 : 0;
            if (ckeCnt >= HOLD) ckePin <= ckeReq;
            ckeCnt <= (ckePin != ckeReq && ckeCnt >= HOLD) ? 0 : ckeCnt + 1;
        end
    end
endmodule

// ===== test/dot_odt_ctrl_tb.sv
`timescale 1ns/10ps
// ==========================================
// Termination control bench
module dot_odt_ctrl_tb;
    logic        clk;
    logic        sys_rst;
    logic [3:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic        odtReq;
    logic        ckeReq;
    logic        odtPin;
    logic        ckePin;
    logic        selfRefresh;
    logic        dllLocked;
    logic        dqDriving;
    logic        rttOn;
    logic [2:0]  rttNomSel;
    logic [1:0]  rttWrSel;
    logic [31:0] rd;
    int          err_count;
    int          checks;
    logic [5:0]  ctrlTab [5] = '{6'h01, 6'h04, 6'h08, 6'h1A, 6'h00};
    logic [7:0]  latTab  [3] = '{8'h35, 8'h48, 8'h02};
    logic [4:0]  modeTab [4] = '{5'b01000, 5'b10000, 5'b10011, 5'b11100};

    dot_odt_ctrl dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .odtPin(odtPin), .ckePin(ckePin),
        .selfRefresh(selfRefresh), .dllLocked(dllLocked),
        .dqDriving(dqDriving), .rttOn(rttOn), .rttNomSel(rttNomSel),
        .rttWrSel(rttWrSel));
    dot_ctrl_model u_ctrl (.clk(clk), .sys_rst(sys_rst), .odtReq(odtReq),
        .ckeReq(ckeReq), .odtPin(odtPin), .ckePin(ckePin));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Pulse ODT; on and off edges must both land exactly lat+3 edges late
    // Model holds the pin seven cycles, so off lands seven after on
    task automatic pulse_check(input int lat, input logic e);
        int i;
        @(posedge clk);
        odtReq <= 1'b1;
        @(posedge clk);
        odtReq <= 1'b0;
        step(lat + 2);
        check("rttOn early", 32'h0, {31'h0, rttOn});
        step(1);
        check("rttOn on", {31'h0, e}, {31'h0, rttOn});
        step(6);
        check("rttOn late", {31'h0, e}, {31'h0, rttOn});
        step(1);
        check("rttOn off", 32'h0, {31'h0, rttOn});
        for (i = 0; i < 20 && odtPin !== 1'b0; i++) step(1);
        if (i == 20) err_count++;
        if (i == 20) tally_and_finish();
    endtask

    initial
    begin
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        odtReq = 1'b0;
        ckeReq = 1'b1;
        selfRefresh = 1'b0;
        dllLocked = 1'b1;
        dqDriving = 1'b0;
        err_count = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        reg_rd(dot_pkg::ADDR_CTRL, rd);
        check("CTRL reset", 32'h0, rd);
        reg_rd(dot_pkg::ADDR_LAT, rd);
        check("LAT reset", 32'h05, rd);
        reg_rd(4'hC, rd);
        check("unmapped", 32'h0, rd);
        // Codes pass through; any nonzero code enables termination
        foreach (ctrlTab[k])
        begin
            reg_wr(dot_pkg::ADDR_CTRL, {26'h0, ctrlTab[k]});
            step(2);
            check("nomSel", {29'h0, ctrlTab[k][2:0]}, {29'h0, rttNomSel});
            check("wrSel", {30'h0, ctrlTab[k][4:3]}, {30'h0, rttWrSel});
            pulse_check(3, ctrlTab[k][4:0] != 5'h00);
        end
        reg_wr(dot_pkg::ADDR_CTRL, 32'h01);
        foreach (latTab[k])
        begin
            reg_wr(dot_pkg::ADDR_LAT, {24'h0, latTab[k]});
            step(4);
            pulse_check((latTab[k][3:0] + latTab[k][7:4] > 3) ?
                latTab[k][3:0] + latTab[k][7:4] - 2 : 1, 1'b1);
        end
        reg_wr(dot_pkg::ADDR_LAT, 32'h05);
        // Modes: dll, cke, self-refresh, keep-DLL bit, expected
        foreach (modeTab[k])
        begin
            dllLocked <= modeTab[k][4];
            ckeReq <= modeTab[k][3];
            selfRefresh <= modeTab[k][2];
            reg_wr(dot_pkg::ADDR_CTRL, {26'h0, modeTab[k][1], 5'h01});
            step(10);
            pulse_check(3, modeTab[k][0]);
        end
        dllLocked <= 1'b1;
        ckeReq <= 1'b1;
        selfRefresh <= 1'b0;
        odtReq <= 1'b1;
        step(12);
        reg_rd(dot_pkg::ADDR_STATUS, rd);
        check("STATUS", 32'h0F, rd);
        dqDriving <= 1'b1;
        step(1);
        check("rttOn drive", 32'h0, {31'h0, rttOn});
        dqDriving <= 1'b0;
        step(1);
        check("rttOn release", 32'h1, {31'h0, rttOn});
        odtReq <= 1'b0;
        step(12);
        tally_and_finish();
    end
endmodule
